/* File: hdl/fbs_pkg.sv */
// Summary of operation
// - Boot delay is a 32-bit read/write millisecond value, preset zero.
// - Bits 0-15 name physical interfaces, bits 16-31 name protocols.
// - Bits 0-6: USB, RS-485, RS-232, CAN, Ethernet, ind. Ethernet, SPI.
// - Protocols: serial Modbus 16, Modbus over TCP 17, industrial IP 18.
// - Availability read-only; ones mark buses present; preset CAN+Ethernet.
// - Control is read/write, switches buses on or off, preset CAN+Ethernet.
// - Control bitmap uses the same bit positions as availability.
// - Status entry 0 is a read-only 8-bit count of two further entries.
// - Status entry 1 is a read-only switchable mask, preset CAN+Ethernet.
// - Status entry 2 is a read-only active bitmap, preset CAN+Ethernet.
// - Active one means running; switchable one means may be deactivated.
`default_nettype none
package fbs_pkg;

    // ----------------------------------------------------------------
    // Object addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_BOOT_DELAY = 16'h2084;
    localparam logic [15:0] IDX_AVAIL = 16'h2101;
    localparam logic [15:0] IDX_CONTROL = 16'h2102;
    localparam logic [15:0] IDX_STATUS = 16'h2103;
    localparam logic [7:0] SUB_VALUE = 8'h00;
    localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] SUB_SWITCHABLE = 8'h01;
    localparam logic [7:0] SUB_ACTIVE = 8'h02;

    // ----------------------------------------------------------------
    // Bitmap layout
    // ----------------------------------------------------------------
    localparam int IFACE_LO = 0;
    localparam int IFACE_HI = 15;
    localparam int PROTO_LO = 16;
    localparam int PROTO_HI = 31;
    localparam int USB_IFACE_BIT = 0;
    localparam int RS485_IFACE_BIT = 1;
    localparam int RS232_IFACE_BIT = 2;
    localparam int CAN_IFACE_BIT = 3;
    localparam int ETHERNET_IFACE_BIT = 4;
    localparam int INDUSTRIAL_ETHERNET_IFACE_BIT = 5;
    localparam int SPI_IFACE_BIT = 6;
    localparam int SERIAL_MODBUS_PROTOCOL_BIT = 16;
    localparam int NETWORKED_MODBUS_PROTOCOL_BIT = 17;
    localparam int INDUSTRIAL_IP_PROTOCOL_BIT = 18;
    localparam logic [31:0] ONE_BIT = 32'h0000_0001;
    localparam logic [31:0] IFACE_BITS = (ONE_BIT << USB_IFACE_BIT)
        | (ONE_BIT << RS485_IFACE_BIT) | (ONE_BIT << RS232_IFACE_BIT)
        | (ONE_BIT << CAN_IFACE_BIT) | (ONE_BIT << ETHERNET_IFACE_BIT)
        | (ONE_BIT << INDUSTRIAL_ETHERNET_IFACE_BIT)
        | (ONE_BIT << SPI_IFACE_BIT);
    localparam logic [31:0] PROTO_BITS =
        (ONE_BIT << SERIAL_MODBUS_PROTOCOL_BIT)
        | (ONE_BIT << NETWORKED_MODBUS_PROTOCOL_BIT)
        | (ONE_BIT << INDUSTRIAL_IP_PROTOCOL_BIT);
    localparam logic [31:0] DEFINED_BITS = IFACE_BITS | PROTO_BITS;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [31:0] BOOT_DELAY_RST = 32'h0000_0000;
    localparam logic [31:0] AVAIL_RST = 32'h0000_0018;
    localparam logic [31:0] CONTROL_RST = 32'h0000_0018;
    localparam logic [31:0] SWITCHABLE_RST = 32'h0000_0018;
    localparam logic [7:0] STATUS_ENTRY_COUNT = 8'h02;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } fbs_od_req_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } fbs_od_rsp_type;

    typedef enum logic {BOOT_WAIT, BOOT_READY} fbs_boot_state_type;

endpackage
`default_nettype wire

/* File: hdl/fbs_top.sv */
`timescale 1ns/10ps
`default_nettype none
module fbs_top
    import fbs_pkg::*;
#(
    parameter logic [31:0] AVAIL_MASK = AVAIL_RST,
    parameter logic [31:0] SWITCH_MASK = SWITCHABLE_RST,
    parameter int CYCLES_PER_MS = MS_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire fbs_od_req_type od_req,
    output fbs_od_rsp_type od_rsp,
    output logic boot_ready,
    output logic [31:0] fieldbus_enable
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    localparam int DIV_W = $clog2(CYCLES_PER_MS);
    if (CYCLES_PER_MS < 2) begin : g_bad_div
        $error("CYCLES_PER_MS must be at least 2");
    end
    if ((AVAIL_MASK & ~DEFINED_BITS) != 32'h0000_0000) begin : g_bad_av
        $error("AVAIL_MASK sets undefined bits");
    end
    if ((SWITCH_MASK & ~AVAIL_MASK) != 32'h0000_0000) begin : g_bad_sw
        $error("SWITCH_MASK must lie inside AVAIL_MASK");
    end

    // ----------------------------------------------------------------
    // Object decode
    // ----------------------------------------------------------------
    logic [31:0] boot_delay_ms;
    logic [31:0] fieldbus_control;
    logic [31:0] next_control;
    fbs_od_rsp_type next_rsp;
    logic req_any;
    logic req_bad;
    logic hit_boot;
    logic hit_avail;
    logic hit_control;
    logic hit_count;
    logic hit_switch;
    logic hit_active;

    // Subindex must match exactly; plain variables only answer on 0
    assign hit_boot = od_req.index == IDX_BOOT_DELAY
        && od_req.subindex == SUB_VALUE;
    assign hit_avail = od_req.index == IDX_AVAIL
        && od_req.subindex == SUB_VALUE;
    assign hit_control = od_req.index == IDX_CONTROL
        && od_req.subindex == SUB_VALUE;
    assign hit_count = od_req.index == IDX_STATUS
        && od_req.subindex == SUB_ENTRY_COUNT;
    assign hit_switch = od_req.index == IDX_STATUS
        && od_req.subindex == SUB_SWITCHABLE;
    assign hit_active = od_req.index == IDX_STATUS
        && od_req.subindex == SUB_ACTIVE;
    // A read and a write together are ambiguous, so both are refused
    assign req_any = od_req.rd | od_req.wr;
    assign req_bad = od_req.rd & od_req.wr;

    // Locked bits keep their value whatever software writes
    assign next_control = (fieldbus_control & ~SWITCH_MASK)
        | (od_req.wdata & SWITCH_MASK);

    // ----------------------------------------------------------------
    // Answer mux
    // ----------------------------------------------------------------
    always_comb begin
        next_rsp = '0;
        next_rsp.ack = req_any;
        if (req_bad) begin
            next_rsp.err = 1'b1;
        end else if (od_req.wr) begin
            // Only the two writable objects take a write
            next_rsp.err = !(hit_boot || hit_control);
        end else if (od_req.rd) begin
            next_rsp.err = 1'b0;
            if (hit_boot) begin
                next_rsp.rdata = boot_delay_ms;
            end else if (hit_avail) begin
                next_rsp.rdata = AVAIL_MASK;
            end else if (hit_control) begin
                next_rsp.rdata = fieldbus_control;
            end else if (hit_count) begin
                next_rsp.rdata = {24'h000000, STATUS_ENTRY_COUNT};
            end else if (hit_switch) begin
                next_rsp.rdata = SWITCH_MASK;
            end else if (hit_active) begin
                next_rsp.rdata = fieldbus_enable;
            end else begin
                next_rsp.err = 1'b1;
            end
        end
    end

    // Answer register, one cycle after the request
    always_ff @(posedge mclk) begin
        if (rst) begin
            od_rsp <= '0;
        end else begin
            od_rsp <= next_rsp;
        end
    end

    // ----------------------------------------------------------------
    // Writable objects
    // ----------------------------------------------------------------
    // Boot delay storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_delay_ms <= BOOT_DELAY_RST;
        end else if (od_req.wr && !od_req.rd && hit_boot) begin
            boot_delay_ms <= od_req.wdata;
        end
    end

    // Control bitmap
    always_ff @(posedge mclk) begin
        if (rst) begin
            fieldbus_control <= CONTROL_RST;
        end else if (od_req.wr && !od_req.rd && hit_control) begin
            fieldbus_control <= next_control;
        end
    end

    // Active bitmap; locked available buses always run
    always_ff @(posedge mclk) begin
        if (rst) begin
            fieldbus_enable <= AVAIL_MASK & (~SWITCH_MASK | CONTROL_RST);
        end else begin
            fieldbus_enable <= AVAIL_MASK
                & (~SWITCH_MASK | fieldbus_control);
        end
    end

    // ----------------------------------------------------------------
    // Boot delay timing
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] ms_div;
    logic ms_tick;
    logic [31:0] ms_count;
    fbs_boot_state_type boot_state;

    // Millisecond divider
    always_ff @(posedge mclk) begin
        if (rst) begin
            ms_div <= '0;
            ms_tick <= 1'b0;
        end else if (ms_div == DIV_W'(CYCLES_PER_MS - 1)) begin
            ms_div <= '0;
            ms_tick <= 1'b1;
        end else begin
            ms_div <= ms_div + 1'b1;
            ms_tick <= 1'b0;
        end
    end

    // Elapsed ms since reset, saturating so it never wraps to ready
    always_ff @(posedge mclk) begin
        if (rst) begin
            ms_count <= '0;
        end else if (ms_tick && ms_count != 32'hffff_ffff) begin
            ms_count <= ms_count + 1'b1;
        end
    end

    // Readiness latches; later delay writes cannot undo it
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_state <= BOOT_WAIT;
            boot_ready <= 1'b0;
        end else begin
            case (boot_state)
                BOOT_WAIT: begin
                    if (ms_count >= boot_delay_ms) begin
                        boot_state <= BOOT_READY;
                        boot_ready <= 1'b1;
                    end
                end
                BOOT_READY: begin
                    boot_ready <= 1'b1;
                end
                default: begin
                    boot_state <= BOOT_WAIT;
                    boot_ready <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_write(logic hit);
        od_req.wr && !od_req.rd && hit;
    endsequence

    sequence s_read(logic hit);
        od_req.rd && !od_req.wr && hit;
    endsequence

    chk_boot_write: assert property (
        s_write(hit_boot) |=> od_rsp.ack && !od_rsp.err
            && boot_delay_ms == $past(od_req.wdata))
        else $error("boot delay write not stored");

    chk_boot_ready: assert property (
        $rose(boot_ready) |-> $past(ms_count >= boot_delay_ms))
        else $error("ready before boot delay ran out");

    chk_avail_ro: assert property (
        s_write(hit_avail) |=> od_rsp.ack && od_rsp.err)
        else $error("availability write not refused");

    chk_avail_read: assert property (
        s_read(hit_avail) |=> od_rsp.rdata == AVAIL_MASK && !od_rsp.err)
        else $error("availability read wrong");

    chk_ctrl_masked: assert property (
        s_write(hit_control) |=> fieldbus_control ==
            (($past(fieldbus_control) & ~SWITCH_MASK)
            | ($past(od_req.wdata) & SWITCH_MASK)))
        else $error("control write touched locked bits");

    chk_count_read: assert property (
        s_read(hit_count) |=> od_rsp.rdata == 32'h0000_0002)
        else $error("entry count wrong");

    chk_switch_read: assert property (
        s_read(hit_switch) |=> od_rsp.rdata == SWITCH_MASK)
        else $error("switchable mask read wrong");

    chk_active_follow: assert property (
        ##1 fieldbus_enable == (AVAIL_MASK
            & (~SWITCH_MASK | $past(fieldbus_control))))
        else $error("active bitmap does not follow control");

    chk_map_defined: assert property (
        (fieldbus_enable & ~DEFINED_BITS) == 32'h0000_0000)
        else $error("undefined bus bit active");

    chk_ack_once: assert property (
        !req_any |=> !od_rsp.ack)
        else $error("answer without request");

    // Every request gets its answer on the very next edge
    chk_ack_each: assert property (
        req_any |=> od_rsp.ack)
        else $error("request left unanswered");

    // Readiness latches; a later delay write must not drop it
    chk_ready_hold: assert property (
        boot_ready |=> boot_ready)
        else $error("boot ready dropped");

endmodule
`default_nettype wire

/* File: dv/fbs_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fbs_top_tb
    import fbs_pkg::*;
;
    // ----------------------------------------------------------------
    // Bench signals
    // ----------------------------------------------------------------
    // Short millisecond so boot timing stays cheap in simulation
    localparam int TB_MS = 4;
    logic mclk;
    logic rst;
    fbs_od_req_type od_req;
    fbs_od_rsp_type od_rsp;
    logic boot_ready;
    logic [31:0] fieldbus_enable;
    int fail_count;
    int samples_checked;
    logic [31:0] exp_val;
    int bit_tbl [10] = '{USB_IFACE_BIT, RS485_IFACE_BIT, RS232_IFACE_BIT,
        CAN_IFACE_BIT, ETHERNET_IFACE_BIT, INDUSTRIAL_ETHERNET_IFACE_BIT,
        SPI_IFACE_BIT, SERIAL_MODBUS_PROTOCOL_BIT,
        NETWORKED_MODBUS_PROTOCOL_BIT, INDUSTRIAL_IP_PROTOCOL_BIT};

    fbs_top #(
        .CYCLES_PER_MS(TB_MS)
    ) i_fbs_top (
        .mclk(mclk),
        .rst(rst),
        .od_req(od_req),
        .od_rsp(od_rsp),
        .boot_ready(boot_ready),
        .fieldbus_enable(fieldbus_enable)
    );

    // Free-running 125 MHz clock
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Compare and count, report mismatches at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    // One object access: strobe for one cycle, answer on the next edge
    task automatic xfer(input logic rd, input logic wr,
        input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wdata, input logic exp_err,
        input logic [31:0] exp_data);
        @(posedge mclk);
        #1;
        od_req.rd = rd;
        od_req.wr = wr;
        od_req.index = idx;
        od_req.subindex = sub;
        od_req.wdata = wdata;
        @(posedge mclk);
        #1;
        od_req.rd = 1'b0;
        od_req.wr = 1'b0;
        check({31'h0, od_rsp.ack}, 32'h1);
        check({31'h0, od_rsp.err}, {31'h0, exp_err});
        // Read data is zero on writes and refusals
        check(od_rsp.rdata, exp_data);
    endtask

    // Reset held 12 cycles; readiness must follow on the first free edge
    task automatic apply_reset;
        @(posedge mclk);
        #1;
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        check({31'h0, boot_ready}, 32'h0);
        rst = 1'b0;
        @(posedge mclk);
        #1;
        check({31'h0, boot_ready}, 32'h1);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        fail_count = 0;
        samples_checked = 0;
        od_req = '0;
        rst = 1'b1;
        apply_reset();
        // Reset values of every object
        xfer(1, 0, IDX_BOOT_DELAY, SUB_VALUE, 0, 0, 32'h0);
        xfer(1, 0, IDX_AVAIL, SUB_VALUE, 0, 0, 32'h18);
        xfer(1, 0, IDX_CONTROL, SUB_VALUE, 0, 0, 32'h18);
        xfer(1, 0, IDX_STATUS, SUB_ENTRY_COUNT, 0, 0, 32'h2);
        xfer(1, 0, IDX_STATUS, SUB_SWITCHABLE, 0, 0, 32'h18);
        xfer(1, 0, IDX_STATUS, SUB_ACTIVE, 0, 0, 32'h18);
        check(fieldbus_enable, 32'h18);
        // Boot delay holds all 32 bits; readiness never drops
        xfer(0, 1, IDX_BOOT_DELAY, SUB_VALUE, 32'hffff_ffff, 0, 0);
        xfer(1, 0, IDX_BOOT_DELAY, SUB_VALUE, 0, 0, 32'hffff_ffff);
        xfer(0, 1, IDX_BOOT_DELAY, SUB_VALUE, 32'h0000_0835, 0, 0);
        xfer(1, 0, IDX_BOOT_DELAY, SUB_VALUE, 0, 0, 32'h0000_0835);
        check({31'h0, boot_ready}, 32'h1);
        // Writes to read-only objects are refused and change nothing
        xfer(0, 1, IDX_AVAIL, SUB_VALUE, 32'h0, 1, 0);
        xfer(0, 1, IDX_STATUS, SUB_ENTRY_COUNT, 32'h0, 1, 0);
        xfer(0, 1, IDX_STATUS, SUB_SWITCHABLE, 32'h0, 1, 0);
        xfer(0, 1, IDX_STATUS, SUB_ACTIVE, 32'h0, 1, 0);
        xfer(1, 0, IDX_AVAIL, SUB_VALUE, 0, 0, 32'h18);
        xfer(1, 0, IDX_STATUS, SUB_SWITCHABLE, 0, 0, 32'h18);
        xfer(1, 0, IDX_STATUS, SUB_ACTIVE, 0, 0, 32'h18);
        // Unmapped places and a read clashing with a write
        xfer(1, 0, IDX_BOOT_DELAY, 8'h01, 0, 1, 0);
        xfer(1, 0, 16'h2085, SUB_VALUE, 0, 1, 0);
        xfer(1, 0, IDX_STATUS, 8'h03, 0, 1, 0);
        xfer(1, 1, IDX_CONTROL, SUB_VALUE, 32'h0, 1, 0);
        // Walk every named bus bit through the control bitmap
        for (int i = 0; i < 10; i++) begin
            exp_val = (ONE_BIT << bit_tbl[i]) & 32'h18;
            xfer(0, 1, IDX_CONTROL, SUB_VALUE, ONE_BIT << bit_tbl[i], 0,
                0);
            xfer(1, 0, IDX_CONTROL, SUB_VALUE, 0, 0, exp_val);
            xfer(1, 0, IDX_STATUS, SUB_ACTIVE, 0, 0, exp_val);
            check(fieldbus_enable, exp_val);
        end
        // Unknown and protocol-half bits are ignored by control
        xfer(0, 1, IDX_CONTROL, SUB_VALUE, 32'hffff_fff7, 0, 0);
        xfer(1, 0, IDX_CONTROL, SUB_VALUE, 0, 0, 32'h10);
        check(fieldbus_enable, 32'h10);
        // Second reset in mid-run restores the presets
        apply_reset();
        xfer(1, 0, IDX_CONTROL, SUB_VALUE, 0, 0, 32'h18);
        xfer(1, 0, IDX_BOOT_DELAY, SUB_VALUE, 0, 0, 32'h0);
        check(fieldbus_enable, 32'h18);
        final_report();
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    // Whole sequence needs well under 500 cycles
    initial begin
        #(8 * 4000);
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
